// *** rtl/wdc_pkg.sv ***
package wdc_pkg;

  // Serial frame layout: write flag, register offset, data byte, MSB first
  localparam int          FRAME_BITS     = 16;
  localparam int          FRAME_WR_POS   = 15;
  localparam int          ADDR_HI        = 14;
  localparam int          ADDR_LO        = 8;
  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 8;
  localparam logic [4:0]  BITCNT_RESET   = 5'h00;
  localparam logic [4:0]  BITCNT_FULL    = 5'h10;
  localparam logic [4:0]  BITCNT_OVER    = 5'h11;

  // Command register offsets
  localparam logic [6:0]  OFS_MAIN_READ_REQ  = 7'h0b;
  localparam logic [6:0]  OFS_WD_READ_REQ    = 7'h0c;
  localparam logic [6:0]  OFS_WINDOW_TIMING  = 7'h15;
  localparam logic [6:0]  OFS_RESPONSE_BYTE  = 7'h16;
  localparam logic [6:0]  OFS_RESPONSE_SYNC  = 7'h17;
  localparam logic [6:0]  OFS_HB_PERIOD      = 7'h18;
  localparam logic [6:0]  OFS_SOFT_RESET     = 7'h1a;
  localparam logic [6:0]  OFS_OUTPUT_ENABLE  = 7'h1c;
  localparam logic [6:0]  OFS_CONFIG_LOCK    = 7'h1e;

  // Read-request field widths
  localparam int          MAIN_REQ_BITS  = 5;
  localparam int          WD_REQ_BITS    = 4;

  // Window timing field positions
  localparam int          CWT_HI         = 7;
  localparam int          CWT_LO         = 2;
  localparam int          OWT_HI         = 1;
  localparam int          OWT_LO         = 0;
  localparam int          HBP_W          = 7;

  // Two-bit command codes
  localparam logic [1:0]  CMD_NONE_A     = 2'h0;
  localparam logic [1:0]  CMD_CLEAR      = 2'h1;
  localparam logic [1:0]  CMD_SET        = 2'h2;
  localparam logic [1:0]  CMD_SOFT_RESET = 2'h3;

  // Reset values of the held bits
  localparam logic        OE_RESET       = 1'b0;
  localparam logic        LOCK_RESET     = 1'b0;

  // Timing: one step of the watchdog grid and the clock rate
  localparam int          STEP_TIME_US   = 1600;
  localparam int          CLK_FREQ_MHZ   = 10;
  localparam int          STEP_CYCLES    = STEP_TIME_US * CLK_FREQ_MHZ;
  localparam int          OPEN_STEPS_PER_CODE = 2;
  localparam int          TIME_W         = 22;

  // Read bank selector for the sequencer
  typedef enum logic {WDC_BANK_MAIN, WDC_BANK_WD} wdc_bank_t;

endpackage : wdc_pkg

// *** rtl/wdc_sync.sv ***
module wdc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : wdc_sync

// *** rtl/wdc_read_seq.sv ***
module wdc_read_seq
  import wdc_pkg::*;
#(
  parameter int MASK_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              load,
  input  wire logic [MASK_W-1:0] mask,
  input  wire wdc_bank_t         bank,
  output logic                   rd_strobe,
  output logic [2:0]             rd_bit,
  output wdc_bank_t              rd_bank,
  output logic                   busy
);
  logic [MASK_W-1:0] pend_reg;
  logic [2:0]        top_bit;

  function automatic logic [2:0] msb_index(input logic [MASK_W-1:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < MASK_W; i++) begin
      if (m[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : msb_index

  assign top_bit = msb_index(pend_reg);

  // One register per cycle, highest request first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg  <= '0;
      rd_strobe <= 1'b0;
      rd_bit    <= 3'h0;
      rd_bank   <= WDC_BANK_MAIN;
      busy      <= 1'b0;
    end else if (load) begin
      pend_reg  <= mask;
      rd_bank   <= bank;
      rd_strobe <= 1'b0;
      busy      <= |mask;
    end else if (|pend_reg) begin
      rd_strobe         <= 1'b1;
      rd_bit            <= top_bit;
      pend_reg[top_bit] <= 1'b0;
      busy              <= 1'b1;
    end else begin
      rd_strobe <= 1'b0;
      busy      <= 1'b0;
    end
  end
endmodule : wdc_read_seq

// *** rtl/wdc_cmd_top.sv ***
module wdc_cmd_top
  import wdc_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES
) (
  clk,
  rst_n,
  spi_cs_n,
  spi_sck,
  spi_mosi,
  spi_miso,
  spi_miso_oe,
  frame_error_clear,
  frame_error_flag,
  read_strobe,
  read_bank,
  read_bit,
  closed_window_time,
  open_window_time,
  window_load,
  closed_window_cycles,
  open_window_cycles,
  response_byte,
  response_valid,
  heartbeat_sync,
  heartbeat_period,
  heartbeat_period_load,
  heartbeat_period_cycles,
  soft_reset_req,
  output_enable,
  config_lock
);
  input  wire logic                  clk;
  input  wire logic                  rst_n;
  input  wire logic                  spi_cs_n;
  input  wire logic                  spi_sck;
  input  wire logic                  spi_mosi;
  output logic                       spi_miso;
  output logic                       spi_miso_oe;
  input  wire logic                  frame_error_clear;
  output logic                       frame_error_flag;
  output logic                       read_strobe;
  output wdc_pkg::wdc_bank_t         read_bank;
  output logic [2:0]                 read_bit;
  output logic [5:0]                 closed_window_time;
  output logic [1:0]                 open_window_time;
  output logic                       window_load;
  output logic [wdc_pkg::TIME_W-1:0] closed_window_cycles;
  output logic [wdc_pkg::TIME_W-1:0] open_window_cycles;
  output logic [7:0]                 response_byte;
  output logic                       response_valid;
  output logic                       heartbeat_sync;
  output logic [6:0]                 heartbeat_period;
  output logic                       heartbeat_period_load;
  output logic [wdc_pkg::TIME_W-1:0] heartbeat_period_cycles;
  output logic                       soft_reset_req;
  output logic                       output_enable;
  output logic                       config_lock;

  // Link pins come from the host's domain
  logic [2:0]  pins_sync;
  logic        cs_n_s;
  logic        sck_s;
  logic        mosi_s;
  logic        cs_prev_reg;
  logic        sck_prev_reg;
  logic [4:0]  bitcnt_reg;
  logic [4:0]  bitcnt_next;
  logic [15:0] shift_reg;
  logic [7:0]  status_reg;
  logic        seq_busy;

  // Synchroniser resets to idle-high so no false frame start follows reset
  wdc_sync #(
    .WIDTH    (3)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({spi_cs_n, spi_sck, spi_mosi}),
    .sync_out (pins_sync)
  );

  assign cs_n_s = pins_sync[2];
  assign sck_s  = pins_sync[1];
  assign mosi_s = pins_sync[0];

  // Edge and frame detection on synchronised levels
  wire frame_start = !cs_n_s && cs_prev_reg;
  wire frame_end   = cs_n_s && !cs_prev_reg;
  wire sck_rise    = !cs_n_s && sck_s && !sck_prev_reg;
  wire sck_fall    = !cs_n_s && !sck_s && sck_prev_reg;

  // Overlong frames saturate so that they stay malformed
  assign bitcnt_next = (bitcnt_reg == BITCNT_OVER) ? BITCNT_OVER : bitcnt_reg + 5'h01;

  // Only a clean 16-bit write frame may act on the commands
  wire frame_ok   = frame_end && (bitcnt_reg == BITCNT_FULL);
  wire frame_bad  = frame_end && (bitcnt_reg != BITCNT_FULL);
  wire wr         = frame_ok && shift_reg[FRAME_WR_POS];
  wire [6:0] addr = shift_reg[ADDR_HI:ADDR_LO];
  wire [7:0] data = shift_reg[DATA_W-1:0];

  // Register decode
  wire hit_main  = wr && (addr == OFS_MAIN_READ_REQ);
  wire hit_wd    = wr && (addr == OFS_WD_READ_REQ);
  wire hit_win   = wr && (addr == OFS_WINDOW_TIMING);
  wire hit_resp  = wr && (addr == OFS_RESPONSE_BYTE);
  wire hit_rsync = wr && (addr == OFS_RESPONSE_SYNC);
  wire hit_hbp   = wr && (addr == OFS_HB_PERIOD);
  wire hit_sr    = wr && (addr == OFS_SOFT_RESET);
  wire hit_oe    = wr && (addr == OFS_OUTPUT_ENABLE);
  wire hit_lock  = wr && (addr == OFS_CONFIG_LOCK);

  wire [5:0] cwt_code = data[CWT_HI:CWT_LO];
  wire [1:0] owt_code = data[OWT_HI:OWT_LO];
  wire [6:0] hbp_code = data[HBP_W-1:0];
  wire [1:0] cmd_code = data[1:0];

  wire cwt_nonzero = (cwt_code != 6'h00);
  wire hbp_nonzero = (hbp_code != 7'h00);

  // Clear and set share one decoder so both held bits treat spare codes alike
  function automatic logic [1:0] clear_set(input logic hit, input logic [1:0] code);
    logic [1:0] act;
    act = 2'b00;
    if (hit && code == CMD_CLEAR) begin
      act = 2'b01;
    end else if (hit && code == CMD_SET) begin
      act = 2'b10;
    end
    return act;
  endfunction : clear_set

  // Strobes fire in the cycle after the frame ends and never linger
  wire [1:0] oe_act    = clear_set(hit_oe, cmd_code);
  wire [1:0] lock_act  = clear_set(hit_lock, cmd_code);
  wire       sr_fire   = hit_sr && (cmd_code == CMD_SOFT_RESET);
  wire       win_fire  = hit_win && cwt_nonzero;
  wire       hbp_fire  = hit_hbp && hbp_nonzero;
  wire       resp_fire = hit_resp || hit_rsync;
  wire       hb_fire   = hit_rsync || hit_hbp;

  // Read requests: only ones matter, zeros are no action
  wire [7:0] main_mask = {3'h0, data[MAIN_REQ_BITS-1:0]};
  wire [7:0] wd_mask   = {4'h0, data[WD_REQ_BITS-1:0]};
  wire       seq_load  = hit_main || hit_wd;
  wire [7:0] seq_mask  = hit_main ? main_mask : wd_mask;
  wire wdc_bank_t seq_bank = hit_main ? WDC_BANK_MAIN : WDC_BANK_WD;

  // Product kept in 32 bits; the longest period still fits in TIME_W
  function automatic logic [TIME_W-1:0] steps_to_cycles(input logic [6:0] steps);
    logic [31:0] prod;
    prod = 32'(steps) * 32'(STEP_CYC);
    return prod[TIME_W-1:0];
  endfunction : steps_to_cycles

  // Open window is a multiple of two grid steps
  wire [6:0] owt_steps = 7'((owt_code + 3'h1) * OPEN_STEPS_PER_CODE);

  // A request arriving mid-sequence replaces the pending one
  wdc_read_seq #(
    .MASK_W    (8)
  ) u_seq (
    .clk       (clk),
    .rst_n     (rst_n),
    .load      (seq_load),
    .mask      (seq_mask),
    .bank      (seq_bank),
    .rd_strobe (read_strobe),
    .rd_bit    (read_bit),
    .rd_bank   (read_bank),
    .busy      (seq_busy)
  );

  // Serial shifter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_reg  <= 1'b1;
      sck_prev_reg <= 1'b0;
      bitcnt_reg   <= BITCNT_RESET;
      shift_reg    <= '0;
    end else begin
      cs_prev_reg  <= cs_n_s;
      sck_prev_reg <= sck_s;
      if (frame_start) begin
        bitcnt_reg <= BITCNT_RESET;
        shift_reg  <= '0;
      end else if (sck_rise) begin
        bitcnt_reg <= bitcnt_next;
        shift_reg  <= {shift_reg[FRAME_BITS-2:0], mosi_s};
      end
    end
  end

  // Flag leads so that a host sees a frame error with the first bit
  wire [7:0] status_word = {frame_error_flag, output_enable, config_lock, seq_busy, 4'h0};

  // Status shifted back to the host: own state, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg  <= '0;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= !cs_n_s;
      if (frame_start) begin
        status_reg <= status_word;
        spi_miso   <= status_word[7];
      end else if (sck_fall) begin
        status_reg <= {status_reg[6:0], 1'b0};
        spi_miso   <= status_reg[6];
      end
    end
  end

  // Frame error flag: a new error wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_error_flag <= 1'b0;
    end else if (frame_bad) begin
      frame_error_flag <= 1'b1;
    end else if (frame_error_clear) begin
      frame_error_flag <= 1'b0;
    end
  end

  // Window timing command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      window_load          <= 1'b0;
      closed_window_time   <= '0;
      open_window_time     <= '0;
      closed_window_cycles <= '0;
      open_window_cycles   <= '0;
    end else begin
      window_load <= win_fire;
      if (win_fire) begin
        closed_window_time   <= cwt_code;
        open_window_time     <= owt_code;
        closed_window_cycles <= steps_to_cycles({1'b0, cwt_code});
        open_window_cycles   <= steps_to_cycles(owt_steps);
      end
    end
  end

  // Functional watchdog response and heartbeat commands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      response_valid          <= 1'b0;
      response_byte           <= '0;
      heartbeat_sync          <= 1'b0;
      heartbeat_period_load   <= 1'b0;
      heartbeat_period        <= '0;
      heartbeat_period_cycles <= '0;
    end else begin
      response_valid        <= resp_fire;
      heartbeat_sync        <= hb_fire;
      heartbeat_period_load <= hbp_fire;
      if (resp_fire) begin
        response_byte <= data;
      end
      if (hbp_fire) begin
        heartbeat_period        <= hbp_code;
        heartbeat_period_cycles <= steps_to_cycles(hbp_code);
      end
    end
  end

  // Guarded global commands; soft reset needs code 3, codes 0 and 3 leave the held bits alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_req <= 1'b0;
      output_enable  <= OE_RESET;
      config_lock    <= LOCK_RESET;
    end else begin
      soft_reset_req <= sr_fire;
      if (oe_act[0]) begin
        output_enable <= 1'b0;
      end else if (oe_act[1]) begin
        output_enable <= 1'b1;
      end
      if (lock_act[0]) begin
        config_lock <= 1'b0;
      end else if (lock_act[1]) begin
        config_lock <= 1'b1;
      end
    end
  end

endmodule : wdc_cmd_top

// *** tb/wdc_cmd_props.sv ***
module wdc_cmd_props #(
  parameter int STEP_CYC = 4
) (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       frame_error_clear,
  input wire logic                       frame_error_flag,
  input wire logic                       read_strobe,
  input wire wdc_pkg::wdc_bank_t         read_bank,
  input wire logic [2:0]                 read_bit,
  input wire logic [5:0]                 closed_window_time,
  input wire logic [1:0]                 open_window_time,
  input wire logic                       window_load,
  input wire logic [wdc_pkg::TIME_W-1:0] closed_window_cycles,
  input wire logic [wdc_pkg::TIME_W-1:0] open_window_cycles,
  input wire logic                       heartbeat_sync,
  input wire logic [6:0]                 heartbeat_period,
  input wire logic                       heartbeat_period_load,
  input wire logic [wdc_pkg::TIME_W-1:0] heartbeat_period_cycles,
  input wire logic                       soft_reset_req
);
  import wdc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  main_range_a: assert property (read_strobe && read_bank == WDC_BANK_MAIN |-> read_bit <= 3'h4)
    else $error("main read bit out of range");
  wd_range_a: assert property (read_strobe && read_bank == WDC_BANK_WD |-> read_bit <= 3'h3)
    else $error("watchdog read bit out of range");
  read_order_a: assert property (read_strobe ##1 (read_strobe && read_bank == $past(read_bank))
    |-> read_bit < $past(read_bit)) else $error("reads not MSB first");
  cwt_nonzero_a: assert property (window_load |=> closed_window_time != 6'h00)
    else $error("zero closed code loaded");
  cwt_scale_a: assert property (window_load |=> closed_window_cycles == closed_window_time * STEP_CYC)
    else $error("closed window cycles wrong");
  owt_scale_a: assert property (window_load |=>
    open_window_cycles == (open_window_time + 1) * 2 * STEP_CYC) else $error("open window wrong");
  hb_sync_a: assert property (heartbeat_period_load |-> heartbeat_sync)
    else $error("period load without sync");
  hb_nonzero_a: assert property (heartbeat_period_load |=> heartbeat_period != 7'h00)
    else $error("zero heartbeat code loaded");
  hb_scale_a: assert property (heartbeat_period_load |=>
    heartbeat_period_cycles == heartbeat_period * STEP_CYC) else $error("period cycles wrong");
  reset_pulse_a: assert property (soft_reset_req |=> !soft_reset_req)
    else $error("soft reset request too long");
  flag_sticky_a: assert property (frame_error_flag && !frame_error_clear |=> frame_error_flag)
    else $error("frame error flag lost");

  cover property (read_strobe ##1 read_strobe ##1 read_strobe);
  cover property (window_load);
  cover property (soft_reset_req);
endmodule : wdc_cmd_props

bind wdc_cmd_top wdc_cmd_props #(.STEP_CYC(STEP_CYC)) wdc_cmd_props_i (
  .clk, .rst_n, .frame_error_clear, .frame_error_flag, .read_strobe, .read_bank, .read_bit,
  .closed_window_time, .open_window_time, .window_load, .closed_window_cycles,
  .open_window_cycles, .heartbeat_sync, .heartbeat_period, .heartbeat_period_load,
  .heartbeat_period_cycles, .soft_reset_req);

// *** tb/wdc_host_model.sv ***
module wdc_host_model (
  input  wire logic clk,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe,
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_mosi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rx;
  logic        oe_all;

  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end

  // Whole frames only; a short count is how a bench asks for a malformed one
  task automatic xfer(input logic [15:0] w, input int nb);
    rx = 16'h0000;
    oe_all = 1'b1;
    spi_cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = nb - 1; i >= 0; i--) begin
      spi_mosi <= w[i];
      repeat (4) @(posedge clk);
      // Status bit has settled a clock before the rising edge it belongs to
      rx = {rx[14:0], spi_miso};
      oe_all = oe_all & spi_miso_oe;
      spi_sck <= 1'b1;
      repeat (4) @(posedge clk);
      spi_sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    spi_cs_n <= 1'b1;
    // Released line must not keep showing the last bit
    spi_mosi <= ~spi_mosi;
  endtask : xfer
endmodule : wdc_host_model

// *** tb/wdc_cmd_top_test.sv ***
module wdc_cmd_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import wdc_pkg::*;
  localparam int SC = 4;
  logic              clk, rst_n, frame_error_clear, spi_cs_n, spi_sck, spi_mosi, spi_miso;
  logic              spi_miso_oe, frame_error_flag, read_strobe, window_load, response_valid;
  logic              heartbeat_sync, heartbeat_period_load, soft_reset_req, output_enable;
  logic              config_lock, eo, el;
  wdc_bank_t         read_bank;
  logic [2:0]        read_bit;
  logic [5:0]        closed_window_time;
  logic [1:0]        open_window_time;
  logic [7:0]        response_byte;
  logic [6:0]        heartbeat_period;
  logic [TIME_W-1:0] closed_window_cycles, open_window_cycles, heartbeat_period_cycles;
  logic [1:0]        codes[5] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h2};
  int                error_cnt, n_compared, cyc, n_rv, n_hs, n_hl, n_wl, n_sr;
  logic [3:0]        rq[$];

  wdc_cmd_top #(.STEP_CYC(SC)) wdc_cmd_top_i (.clk, .rst_n, .spi_cs_n, .spi_sck, .spi_mosi,
    .spi_miso, .spi_miso_oe, .frame_error_clear, .frame_error_flag, .read_strobe, .read_bank,
    .read_bit, .closed_window_time, .open_window_time, .window_load, .closed_window_cycles,
    .open_window_cycles, .response_byte, .response_valid, .heartbeat_sync, .heartbeat_period,
    .heartbeat_period_load, .heartbeat_period_cycles, .soft_reset_req, .output_enable,
    .config_lock);
  wdc_host_model wdc_host_model_i (.clk, .spi_miso, .spi_miso_oe, .spi_cs_n, .spi_sck, .spi_mosi);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Pulses are counted per frame since they stand for one cycle only
  always @(posedge clk) begin
    cyc++;
    if (read_strobe) rq.push_back({read_bank, read_bit});
    n_rv += response_valid;
    n_hs += heartbeat_sync;
    n_hl += heartbeat_period_load;
    n_wl += window_load;
    n_sr += soft_reset_req;
    if (cyc > 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results;
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [6:0] ofs, input logic [7:0] d, input int nb = 16,
                    input logic w = 1'b1);
    n_rv = 0;
    n_hs = 0;
    n_hl = 0;
    n_wl = 0;
    n_sr = 0;
    rq.delete();
    wdc_host_model_i.xfer({w, ofs, d}, nb);
    repeat (16) @(posedge clk);
  endtask : wr

  task automatic rdq(input logic [6:0] ofs, input logic [7:0] d, input wdc_bank_t bk,
                     input int nb);
    logic [3:0] e[$];
    for (int i = nb - 1; i >= 0; i--) if (d[i]) e.push_back({bk, i[2:0]});
    wr(ofs, d);
    chk("read count", e.size(), rq.size());
    foreach (e[k]) chk("read order", e[k], rq[k]);
  endtask : rdq

  initial begin
    rst_n = 1'b0;
    frame_error_clear = 1'b0;
    eo = 1'b0;
    el = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset state", 0, {output_enable, config_lock, frame_error_flag, heartbeat_period});
    rdq(OFS_MAIN_READ_REQ, 8'h15, WDC_BANK_MAIN, 5);
    rdq(OFS_MAIN_READ_REQ, 8'hff, WDC_BANK_MAIN, 5);
    rdq(OFS_MAIN_READ_REQ, 8'h00, WDC_BANK_MAIN, 5);
    rdq(OFS_WD_READ_REQ, 8'hff, WDC_BANK_WD, 4);
    rdq(OFS_WD_READ_REQ, 8'h0a, WDC_BANK_WD, 4);
    wr(OFS_WINDOW_TIMING, 8'hff);
    chk("closed cycles", 63 * SC, closed_window_cycles);
    wr(OFS_WINDOW_TIMING, 8'h01);
    chk("window zero", {2'd0, 6'h3f, 2'h3}, {n_wl[1:0], closed_window_time, open_window_time});
    for (int c = 0; c < 4; c++) begin
      wr(OFS_WINDOW_TIMING, {6'h01, c[1:0]});
      chk("window codes", {2'd1, 6'h01, c[1:0]},
          {n_wl[1:0], closed_window_time, open_window_time});
      chk("closed step", SC, closed_window_cycles);
      chk("open cycles", (c + 1) * 2 * SC, open_window_cycles);
    end
    wr(OFS_RESPONSE_BYTE, 8'ha5);
    chk("response", {8'ha5, 2'd1, 2'd0}, {response_byte, n_rv[1:0], n_hs[1:0]});
    wr(OFS_RESPONSE_SYNC, 8'h5a);
    chk("response sync", {8'h5a, 2'd1, 2'd1}, {response_byte, n_rv[1:0], n_hs[1:0]});
    wr(OFS_HB_PERIOD, 8'h7f);
    chk("hb period", {2'd1, 22'(127 * SC)}, {n_hs[1:0], heartbeat_period_cycles});
    wr(OFS_HB_PERIOD, 8'h00);
    chk("hb zero", {7'h7f, 2'd0}, {heartbeat_period, n_hl[1:0]});
    wr(OFS_HB_PERIOD, 8'h02);
    chk("hb step", 2 * SC, heartbeat_period_cycles);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SOFT_RESET, {6'h00, c[1:0]});
      chk("soft reset", c == 3, n_sr);
    end
    foreach (codes[i]) begin
      eo = codes[i] == 2'h1 ? 1'b0 : codes[i] == 2'h2 ? 1'b1 : eo;
      el = ~codes[i] == 2'h1 ? 1'b0 : ~codes[i] == 2'h2 ? 1'b1 : el;
      wr(OFS_OUTPUT_ENABLE, {6'h00, codes[i]});
      chk("output enable", eo, output_enable);
      wr(OFS_CONFIG_LOCK, {6'h00, ~codes[i]});
      chk("config lock", el, config_lock);
    end
    wr(OFS_OUTPUT_ENABLE, 8'h01, 16, 1'b0);
    chk("read frame", 1'b1, output_enable);
    wr(OFS_OUTPUT_ENABLE, 8'h01, 15);
    chk("frame error", 2'b11, {frame_error_flag, output_enable});
    wr(OFS_SOFT_RESET, 8'h00);
    chk("status out", {1'b1, eo, el, 13'h0000}, wdc_host_model_i.rx);
    chk("status enable", 3'b100, {wdc_host_model_i.oe_all, spi_miso_oe, n_sr[0]});
    frame_error_clear <= 1'b1;
    @(posedge clk);
    frame_error_clear <= 1'b0;
    repeat (2) @(posedge clk);
    chk("error clear", 1'b0, frame_error_flag);
    wr(OFS_SOFT_RESET, 8'h00);
    chk("status clear", {1'b0, eo, el, 13'h0000}, wdc_host_model_i.rx);
    results();
  end
endmodule : wdc_cmd_top_test
